// ---- design/cmpc_pkg.sv ----
package cmpc_pkg;
    // register indices; byte address is four times the index
    localparam logic [2:0] CMPC_IDX_CTRL = 3'h0;
    localparam logic [2:0] CMPC_IDX_MUX = 3'h2;
    localparam logic [2:0] CMPC_IDX_DAC = 3'h5;
    localparam logic [2:0] CMPC_IDX_IRQC = 3'h6;
    localparam logic [2:0] CMPC_IDX_STAT = 3'h7;
    localparam int CMPC_ADDR_LSB = 2;
    localparam int CMPC_ADDR_W = 5;

    // reset values
    localparam logic [7:0] CMPC_RST_CTRL = 8'h00;
    localparam logic [7:0] CMPC_RST_MUX = 8'h00;
    localparam logic [7:0] CMPC_RST_DAC = 8'hff;
    localparam logic [7:0] CMPC_RST_IRQC = 8'h00;

    // comparator_control_a fields
    localparam int CMPC_CTRL_ENABLE = 0;
    localparam int CMPC_CTRL_HYS_LO = 1;
    localparam int CMPC_CTRL_PWR_LO = 3;
    localparam int CMPC_CTRL_OUTPUT_PAD_ENABLE = 6;
    localparam int CMPC_CTRL_STBY = 7;
    localparam logic [7:0] CMPC_CTRL_MASK = 8'hdf;

    // input_select_control fields
    localparam int CMPC_MUX_NEG_LO = 0;
    localparam int CMPC_MUX_POS_LO = 3;
    localparam int CMPC_MUX_INIT = 6;
    localparam int CMPC_MUX_INV = 7;

    // irq_control fields
    localparam int CMPC_IRQC_EN = 0;
    localparam int CMPC_IRQC_MODE_LO = 4;
    localparam logic [7:0] CMPC_IRQC_MASK = 8'h31;

    // comparator_status fields
    localparam int CMPC_STAT_FLAG = 0;
    localparam int CMPC_STAT_STATE = 4;

    // irq_edge_select encodings
    localparam logic [1:0] CMPC_EDGE_BOTH = 2'h0;
    localparam logic [1:0] CMPC_EDGE_FALL = 2'h2;
    localparam logic [1:0] CMPC_EDGE_RISE = 2'h3;

    // hysteresis_select and power profile codes
    localparam logic [1:0] CMPC_HYS_NONE = 2'h0;
    localparam logic [1:0] CMPC_HYS_LARGE = 2'h3;
    localparam logic [1:0] CMPC_PWR_FASTEST = 2'h0;

    // positive_input_select / negative_input_select codes
    localparam logic [2:0] CMPC_POS_PIN0 = 3'h0;
    localparam logic [2:0] CMPC_POS_PIN3 = 3'h3;
    localparam logic [2:0] CMPC_POS_PIN4 = 3'h4;
    localparam logic [2:0] CMPC_NEG_PIN0 = 3'h0;
    localparam logic [2:0] CMPC_NEG_PIN2 = 3'h2;
    localparam logic [2:0] CMPC_NEG_PIN3 = 3'h3;
    localparam logic [2:0] CMPC_NEG_THRESHOLD_CODE = 3'h4;

    // threshold divider denominator
    localparam int CMPC_DAC_STEPS = 256;

    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] mux;
        logic [7:0] dac;
        logic [7:0] irqc;
        logic flag;
        logic sync1;
        logic sync2;
        logic state;
        logic prev;
        logic prev_valid;
        logic active;
        logic out_level;
        logic pad_oe;
        logic irq;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } cmpc_state_t;
endpackage : cmpc_pkg

// ---- design/cmpc_top.sv ----
`timescale 1ns/1ps
// Overview of operation
// - the selected comparator transition sets the interrupt flag in status
// - edge select chooses rising, falling or both comparator edges for the interrupt
// - interrupt request is forwarded only while the enable bit is one
// - the interrupt request stays high as long as the flag is set
// - idle sleep changes nothing: comparing, flagging and output continue
// - standby halts the comparator unless standby_run is one
// - in standby edges do not set the interrupt flag, but the clocked state bit in status still updates
// - power-down disables the comparator and its pin output
// - output_pad_enable (control bit 6) drives the comparator output onto the pin
// - two-bit power profile at bits 4:3, zero is fastest
// - two-bit hysteresis select at bits 2:1: none, small, medium, large
// - control bit 0 turns the comparator on, zero keeps it off
// - mux bit 7 inverts the result for pin, event and status state; interrupt edges use the uninverted result
// - until ready, the output holds initial_output_level from mux bit 6
// - positive select at bits 5:3, codes 0, 3, 4 pick pins, others reserved
// - negative select at bits 2:0, codes 0, 2, 3 pins, 4 threshold reference
// - eight-bit threshold code, reset 0xff, gives code/256 of the reference
// - raw result is one when positive input exceeds negative input
// - edge select codes: 0 both, 2 falling, 3 rising, 1 reserved
// - writing one to the flag bit clears it, zero has no effect
// - output_state reads the comparator output through a three-cycle synchronizer
module cmpc_top
    import cmpc_pkg::*;
(
    input wire logic pclk, // peripheral clock
    input wire logic presetn, // asynchronous reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb direction
    input wire logic [CMPC_ADDR_W-1:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    input wire logic [3:0] pstrb, // apb byte strobes
    output logic pready, // apb ready
    output logic [31:0] prdata, // apb read data
    output logic pslverr, // apb error on unmapped address
    input wire logic sleep_idle, // system in idle sleep
    input wire logic sleep_standby, // system in standby sleep
    input wire logic sleep_powerdown, // system in power-down sleep
    input wire logic comp_result, // analog result, positive above negative
    input wire logic comp_ready, // analog core has settled after enable
    output logic comp_enable, // turns the analog core on
    output logic [1:0] power_profile, // analog current setting
    output logic [1:0] hysteresis_select, // analog hysteresis level
    output logic [2:0] positive_input_select, // positive mux code
    output logic [2:0] negative_input_select, // negative mux code
    output logic [7:0] threshold_dac_code, // internal divider code
    output logic cmp_event, // event output level
    output logic pad_out, // pin output value
    output logic pad_oe, // pin output enable
    output logic irq // interrupt request
);

    cmpc_state_t cur_ff;
    cmpc_state_t nxt_ff;

    // merge written bytes of lane 0 under a field mask
    function automatic logic [7:0] cmpc_wr(input logic [7:0] old, input logic [7:0] wd,
                                          input logic strb, input logic [7:0] mask);
        cmpc_wr = strb ? ((wd & mask) | (old & ~mask)) : old;
    endfunction : cmpc_wr

    logic [2:0] idx;
    logic idx_ok;
    logic setup;
    logic access_done;
    logic do_write;
    logic running;
    logic pre_now;
    logic pre_old;
    logic rise;
    logic fall;
    logic edge_hit;
    logic [1:0] mode;
    logic [7:0] stat_rd;

    always_comb begin
        nxt_ff = cur_ff;
        idx = paddr[CMPC_ADDR_LSB +: 3];
        idx_ok = (paddr[CMPC_ADDR_LSB-1:0] == 2'h0) &&
                 (idx == CMPC_IDX_CTRL || idx == CMPC_IDX_MUX || idx == CMPC_IDX_DAC ||
                  idx == CMPC_IDX_IRQC || idx == CMPC_IDX_STAT);
        setup = psel && !penable;
        access_done = psel && penable && cur_ff.pready;
        do_write = access_done && pwrite && idx_ok;

        // comparator runs when enabled and not halted by sleep
        running = cur_ff.ctrl[CMPC_CTRL_ENABLE] && !sleep_powerdown &&
                  !(sleep_standby && !cur_ff.ctrl[CMPC_CTRL_STBY]);
        nxt_ff.active = running;

        // synchronizer chain; the third stage is the visible state
        nxt_ff.sync1 = comp_result;
        nxt_ff.sync2 = cur_ff.sync1;
        if (running && comp_ready) begin
            nxt_ff.state = cur_ff.sync2 ^ cur_ff.mux[CMPC_MUX_INV];
        end else begin
            nxt_ff.state = cur_ff.mux[CMPC_MUX_INIT];
        end
        nxt_ff.out_level = running ? nxt_ff.state : 1'b0;
        nxt_ff.pad_oe = running && cur_ff.ctrl[CMPC_CTRL_OUTPUT_PAD_ENABLE];

        // edges judged on the uninverted comparison
        pre_now = cur_ff.state ^ cur_ff.mux[CMPC_MUX_INV];
        pre_old = cur_ff.prev;
        nxt_ff.prev = pre_now;
        nxt_ff.prev_valid = running && comp_ready;
        rise = pre_now && !pre_old;
        fall = !pre_now && pre_old;
        mode = cur_ff.irqc[CMPC_IRQC_MODE_LO +: 2];
        unique case (mode)
            CMPC_EDGE_BOTH: edge_hit = rise || fall;
            CMPC_EDGE_FALL: edge_hit = fall;
            CMPC_EDGE_RISE: edge_hit = rise;
            default: edge_hit = 1'b0;
        endcase
        edge_hit = edge_hit && cur_ff.prev_valid && running && !sleep_standby;

        // apb answer one cycle after setup
        nxt_ff.pready = setup;
        if (setup) begin
            nxt_ff.pslverr = !idx_ok;
            nxt_ff.prdata = 32'h0;
            stat_rd = 8'h00;
            stat_rd[CMPC_STAT_STATE] = cur_ff.state;
            stat_rd[CMPC_STAT_FLAG] = cur_ff.flag;
            if (!pwrite) begin
                unique case (idx)
                    CMPC_IDX_CTRL: nxt_ff.prdata[7:0] = cur_ff.ctrl;
                    CMPC_IDX_MUX: nxt_ff.prdata[7:0] = cur_ff.mux;
                    CMPC_IDX_DAC: nxt_ff.prdata[7:0] = cur_ff.dac;
                    CMPC_IDX_IRQC: nxt_ff.prdata[7:0] = cur_ff.irqc;
                    CMPC_IDX_STAT: nxt_ff.prdata[7:0] = stat_rd;
                    default: nxt_ff.prdata = 32'h0;
                endcase
            end
        end else begin
            stat_rd = 8'h00;
            if (access_done) begin
                nxt_ff.pslverr = 1'b0;
                nxt_ff.prdata = 32'h0;
            end
        end

        if (do_write) begin
            unique case (idx)
                CMPC_IDX_CTRL: nxt_ff.ctrl = cmpc_wr(cur_ff.ctrl, pwdata[7:0], pstrb[0],
                                                     CMPC_CTRL_MASK);
                CMPC_IDX_MUX: nxt_ff.mux = cmpc_wr(cur_ff.mux, pwdata[7:0], pstrb[0],
                                                   8'hff);
                CMPC_IDX_DAC: nxt_ff.dac = cmpc_wr(cur_ff.dac, pwdata[7:0], pstrb[0],
                                                   8'hff);
                CMPC_IDX_IRQC: nxt_ff.irqc = cmpc_wr(cur_ff.irqc, pwdata[7:0], pstrb[0],
                                                     CMPC_IRQC_MASK);
                CMPC_IDX_STAT: begin
                    if (pstrb[0] && pwdata[CMPC_STAT_FLAG]) begin
                        nxt_ff.flag = 1'b0;
                    end
                end
                default: nxt_ff.flag = cur_ff.flag;
            endcase
        end

        // a new edge beats a clear in the same cycle
        if (edge_hit) begin
            nxt_ff.flag = 1'b1;
        end
        nxt_ff.irq = nxt_ff.flag && nxt_ff.irqc[CMPC_IRQC_EN];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur_ff <= '{ctrl: CMPC_RST_CTRL, mux: CMPC_RST_MUX, dac: CMPC_RST_DAC,
                        irqc: CMPC_RST_IRQC, prdata: 32'h0, default: 1'b0};
        end else begin
            cur_ff <= nxt_ff;
        end
    end

    assign pready = cur_ff.pready;
    assign prdata = cur_ff.prdata;
    assign pslverr = cur_ff.pslverr;
    assign comp_enable = cur_ff.active;
    assign power_profile = cur_ff.ctrl[CMPC_CTRL_PWR_LO +: 2];
    assign hysteresis_select = cur_ff.ctrl[CMPC_CTRL_HYS_LO +: 2];
    assign positive_input_select = cur_ff.mux[CMPC_MUX_POS_LO +: 3];
    assign negative_input_select = cur_ff.mux[CMPC_MUX_NEG_LO +: 3];
    assign threshold_dac_code = cur_ff.dac;
    assign cmp_event = cur_ff.out_level;
    assign pad_out = cur_ff.out_level;
    assign pad_oe = cur_ff.pad_oe;
    assign irq = cur_ff.irq;

endmodule : cmpc_top

// ---- tb/cmpc_checker.sv ----
`timescale 1ns/1ps
module cmpc_checker
    import cmpc_pkg::*;
(
    input wire logic pclk, // clock
    input wire logic presetn, // reset
    input wire logic psel, // apb select
    input wire logic penable, // apb access
    input wire logic pwrite, // apb direction
    input wire logic pready, // apb ready
    input wire logic [31:0] prdata, // apb read data
    input wire logic pslverr, // apb error
    input wire logic sleep_powerdown, // power-down
    input wire logic comp_enable, // core on
    input wire logic cmp_event, // event level
    input wire logic pad_out, // pin value
    input wire logic pad_oe, // pin enable
    input wire logic irq // request
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    a_ready_one_cycle: assert property (pready |=> !pready) else $error("ready held");
    a_rdata_idle_zero: assert property (!pready |-> prdata == 32'h0) else $error("stale rdata");
    a_err_with_ready: assert property (pslverr |-> pready) else $error("lone error");
    a_irq_holds_flag: assert property (irq && !(psel && penable && pwrite) |=> irq)
        else $error("irq dropped");
    a_powerdown_off: assert property (sleep_powerdown |=> !comp_enable && !pad_oe)
        else $error("on in power-down");
    a_pad_needs_core: assert property (pad_oe |-> comp_enable) else $error("pad without core");
    a_off_output_low: assert property (!comp_enable ##1 !comp_enable |-> !pad_out && !cmp_event)
        else $error("output while off");
    a_event_pad_same: assert property (cmp_event == pad_out) else $error("event and pin differ");
endmodule : cmpc_checker
bind cmpc_top cmpc_checker u_cmpc_checker (.pclk, .presetn, .psel, .penable, .pwrite, .pready,
    .prdata, .pslverr, .sleep_powerdown, .comp_enable, .cmp_event, .pad_out, .pad_oe, .irq);

// ---- tb/cmpc_core_model.sv ----
`timescale 1ns/1ps
module cmpc_core_model #(parameter int READY_DLY = 10) (
    input wire logic pclk, // clock
    input wire logic comp_enable, // core power
    input wire logic level, // outcome set by the bench
    output logic comp_result, // raw result
    output logic comp_ready // settled
);
    int cnt = 0;
    logic junk = 1'b0;
    always @(posedge pclk) begin
        junk <= ~junk;
        if (!comp_enable) cnt <= 0;
        else if (cnt < READY_DLY) cnt <= cnt + 1;
    end
    // a halted core gives no meaningful result
    assign comp_result = comp_enable ? level : junk;
    assign comp_ready = comp_enable && cnt == READY_DLY;
endmodule : cmpc_core_model

// ---- tb/comparator_control_logic_test.sv ----
`timescale 1ns/1ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin n_mismatch++; \
    $display("[ERR] %s exp %h got %h", n, e, g); end end
module comparator_control_logic_test;
    import cmpc_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err, want;
    logic [4:0] paddr = 5'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [3:0] pstrb = 4'hf;
    logic sleep_idle = 0, sleep_standby = 0, sleep_powerdown = 0, level = 0;
    logic pready, pslverr, comp_result, comp_ready, comp_enable, cmp_event, pad_out, pad_oe, irq;
    logic [1:0] power_profile, hysteresis_select;
    logic [2:0] positive_input_select, negative_input_select;
    logic [7:0] threshold_dac_code;
    int n_mismatch = 0, comparisons = 0;
    cmpc_top u_cmpc_top (
        .pclk(pclk),
        .presetn(presetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .pstrb(pstrb),
        .pready(pready),
        .prdata(prdata),
        .pslverr(pslverr),
        .sleep_idle(sleep_idle),
        .sleep_standby(sleep_standby),
        .sleep_powerdown(sleep_powerdown),
        .comp_result(comp_result),
        .comp_ready(comp_ready),
        .comp_enable(comp_enable),
        .power_profile(power_profile),
        .hysteresis_select(hysteresis_select),
        .positive_input_select(positive_input_select),
        .negative_input_select(negative_input_select),
        .threshold_dac_code(threshold_dac_code),
        .cmp_event(cmp_event),
        .pad_out(pad_out),
        .pad_oe(pad_oe),
        .irq(irq)
    );
    cmpc_core_model u_cmpc_core_model (.pclk, .comp_enable, .level, .comp_result, .comp_ready);
    initial forever #5 pclk = ~pclk;
    task automatic apb(input logic wr, input logic [4:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 20) begin
            n++;
            @(posedge pclk);
        end
        if (n == 20) n_mismatch++;
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
        // let the write settle before the caller looks at register outputs
        @(posedge pclk);
    endtask : apb
    task automatic rchk(input logic [4:0] a, input logic [7:0] e, input string nm);
        apb(0, a, 8'h00);
        `CHK(nm, {24'h0, e}, rd)
    endtask : rchk
    task automatic t_regs;
        rchk(5'h00, 8'h00, "ctrl");
        rchk(5'h08, 8'h00, "mux");
        rchk(5'h14, 8'hff, "dac");
        rchk(5'h18, 8'h00, "irqc");
        apb(1, 5'h00, 8'hff);
        rchk(5'h00, 8'hdf, "ctrl rw");
        `CHK("enable", 1'b1, comp_enable)
        `CHK("power", 2'h3, power_profile)
        `CHK("hyst", 2'h3, hysteresis_select)
        apb(1, 5'h00, 8'h00);
        repeat (2) @(posedge pclk);
        `CHK("disable", 1'b0, comp_enable)
        apb(1, 5'h14, 8'h5a);
        `CHK("dac out", 8'h5a, threshold_dac_code)
        pstrb <= 4'he;
        apb(1, 5'h14, 8'h33);
        pstrb <= 4'hf;
        rchk(5'h14, 8'h5a, "dac no strobe");
        apb(0, 5'h04, 8'h00);
        `CHK("unmapped", 1'b1, err)
        `CHK("unmapped rd", 32'h0, rd)
        apb(0, 5'h01, 8'h00);
        `CHK("misaligned", 1'b1, err)
        $display("regs done");
    endtask : t_regs
    task automatic t_mux;
        logic [2:0] p, q;
        for (int i = 0; i < 3; i++) begin
            for (int j = 0; j < 4; j++) begin
                p = (i == 0) ? 3'h0 : 3'(i + 2);
                q = (j == 0) ? 3'h0 : 3'(j + 1);
                apb(1, 5'h08, {2'b00, p, q});
                `CHK("pos", p, positive_input_select)
                `CHK("neg", q, negative_input_select)
            end
        end
        $display("mux done");
    endtask : t_mux
    task automatic t_edges;
        sleep_idle <= 1;
        apb(1, 5'h08, 8'h00);
        apb(1, 5'h00, 8'h01);
        repeat (20) @(posedge pclk);
        for (int m = 0; m < 4; m++) begin
            apb(1, 5'h18, {2'b00, 2'(m), 4'h1});
            for (int e = 0; e < 2; e++) begin
                apb(1, 5'h1c, 8'h01);
                level <= ~level;
                repeat (8) @(posedge pclk);
                want = (m == 0) || (m == 3 && e == 0) || (m == 2 && e == 1);
                `CHK("irq", want, irq)
                rchk(5'h1c, {3'h0, level, 3'h0, want}, "status");
            end
        end
        apb(1, 5'h18, 8'h00);
        apb(1, 5'h1c, 8'h01);
        level <= 1;
        repeat (8) @(posedge pclk);
        `CHK("irq off", 1'b0, irq)
        apb(1, 5'h1c, 8'h00);
        rchk(5'h1c, 8'h11, "w0 kept");
        apb(1, 5'h1c, 8'h01);
        rchk(5'h1c, 8'h10, "w1 clr");
        sleep_idle <= 0;
        $display("edges done");
    endtask : t_edges
    task automatic t_sleep;
        apb(1, 5'h00, 8'h41);
        repeat (20) @(posedge pclk);
        `CHK("pad oe", 1'b1, pad_oe)
        `CHK("pad", 1'b1, pad_out)
        sleep_powerdown <= 1;
        repeat (3) @(posedge pclk);
        `CHK("pd en", 1'b0, comp_enable)
        `CHK("pd oe", 1'b0, pad_oe)
        sleep_powerdown <= 0;
        sleep_standby <= 1;
        repeat (3) @(posedge pclk);
        `CHK("sb halt", 1'b0, comp_enable)
        apb(1, 5'h00, 8'hc1);
        apb(1, 5'h18, 8'h01);
        apb(1, 5'h1c, 8'h01);
        repeat (20) @(posedge pclk);
        `CHK("sb run", 1'b1, comp_enable)
        level <= 0;
        repeat (8) @(posedge pclk);
        `CHK("sb irq", 1'b0, irq)
        sleep_standby <= 0;
        apb(1, 5'h00, 8'h00);
        apb(1, 5'h1c, 8'h01);
        $display("sleep done");
    endtask : t_sleep
    task automatic t_init;
        apb(1, 5'h08, 8'h40);
        apb(1, 5'h00, 8'h41);
        repeat (5) @(posedge pclk);
        `CHK("init", 1'b1, pad_out)
        repeat (20) @(posedge pclk);
        `CHK("ready", 1'b0, pad_out)
        apb(1, 5'h08, 8'h80);
        repeat (8) @(posedge pclk);
        `CHK("inv pad", 1'b1, pad_out)
        `CHK("inv evt", 1'b1, cmp_event)
        $display("init done");
    endtask : t_init
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : close_out
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1;
        t_regs;
        t_mux;
        t_edges;
        t_sleep;
        t_init;
        close_out;
    end
    initial begin
        #200000;
        n_mismatch++;
        close_out;
    end
endmodule : comparator_control_logic_test
